// File: rtl/pcr_pkg.sv
// Shared constants for the processor control register bank and system timer
package pcr_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned WORD_W = 32;   // Every control register is one word
  localparam int unsigned NUM_REGS = 16; // Registers addressed by number 0..15
  localparam int unsigned NUM_W = 4;     // Width of a register number

  // ----------------------------------------------------------------
  // Register numbers
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_RELOAD = 4'h6;  // timer_reload_source
  localparam logic [3:0] REG_COUNT = 4'h7;   // timer_down_counter
  localparam logic [3:0] REG_TSTAT = 4'h8;   // timer_status_word
  localparam logic [3:0] REG_MDEXT = 4'hA;   // multiply_divide_extension
  localparam logic [3:0] REG_ERR = 4'hB;     // error_check_status
  localparam logic [3:0] REG_IRB = 4'hC;     // soft_interrupt_request
  localparam logic [3:0] REG_IPTR = 4'hD;    // next_instruction_pointer
  localparam logic [3:0] REG_ICW = 4'hE;     // interrupt_control_word
  localparam logic [3:0] REG_FLAGS = 4'hF;   // condition_flags

  // ----------------------------------------------------------------
  // Implemented-bit masks (vector index = 31 - documented bit)
  // ----------------------------------------------------------------
  localparam logic [31:0] MASK_FULL = 32'hFFFFFFFF; // Whole-word registers
  localparam logic [31:0] MASK_HALF = 32'h0000FFFF; // Doc bits 16..31
  localparam logic [31:0] MASK_TSTAT = 32'h00000077; // Doc bits 25-27, 29-31
  localparam logic [31:0] MASK_IPTR = 32'hFFFFFFFE; // Doc bit 31 held at 0
  localparam logic [31:0] MASK_FLAGS = 32'h0000007B; // Doc bits 25-28, 30, 31
  localparam logic [31:0] MASK_NONE = 32'h00000000; // Reserved registers

  // ----------------------------------------------------------------
  // Field positions, as documented (big-endian bit numbers)
  // ----------------------------------------------------------------
  localparam logic [4:0] TS_ENABLE_BIT = 5'h19;   // Bit 25
  localparam logic [4:0] TS_STATUS_BIT = 5'h1A;   // Bit 26
  localparam logic [4:0] TS_OVERFLOW_BIT = 5'h1B; // Bit 27
  localparam int unsigned TS_PRIO_LSB = 0;        // Bits 29-31 at index 2:0
  localparam logic [4:0] IRB_BASE_BIT = 5'h10;    // Level n is bit 16+n
  localparam logic [4:0] PZERO_BIT = 5'h18;       // Bit 24
  localparam logic [4:0] LT_BIT = 5'h19;          // Bit 25
  localparam logic [4:0] EQ_BIT = 5'h1A;          // Bit 26
  localparam logic [4:0] GT_BIT = 5'h1B;          // Bit 27
  localparam logic [4:0] CARRY_BIT = 5'h1C;       // Bit 28
  localparam logic [4:0] OVF_BIT = 5'h1E;         // Bit 30
  localparam logic [4:0] TB_BIT = 5'h1F;          // Bit 31
  localparam logic [4:0] BRANCH_BASE = 5'h10;     // Branch selector base
  localparam logic [4:0] JUMP_BASE = 5'h18;       // Jump selector base

  // ----------------------------------------------------------------
  // Reset values and timer constants
  // ----------------------------------------------------------------
  localparam logic [31:0] RESET_WORD = 32'h00000000; // All registers clear
  localparam logic [31:0] COUNT_ONE = 32'h00000001;  // Alarm threshold
  localparam logic [31:0] COUNT_ZERO = 32'h00000000; // Wrap case
  localparam int unsigned DEF_IRB_LEVELS = 7;        // Levels 0..6

  // ----------------------------------------------------------------
  // Flag update kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PCR_FK_LOGIC,  // Logical or shift result
    PCR_FK_ARITH,  // Add or subtract, all flags
    PCR_FK_CMP,    // Signed compare of operands
    PCR_FK_NONE    // No flag change
  } pcr_flag_kind_t;

endpackage

// File: rtl/pcr_tick_edge.sv
// Falling-edge detector for the active-low external timer tick
`timescale 1ns/1ps
module pcr_tick_edge (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Tick input, active low
  input wire logic tick_n,
  // One-cycle pulse on inactive-to-active transition
  output logic tick_pulse
);

  // ----------------------------------------------------------------
  // Previous level
  // ----------------------------------------------------------------
  logic prev_ff;  // Last sampled tick level
  logic nxt_prev; // Next sampled level

  // Next value is the current level
  always_comb begin
    nxt_prev = tick_n;
  end

  // Reset as inactive so a low tick at release counts as an edge
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prev_ff <= 1'b1;
    end else begin
      prev_ff <= nxt_prev;
    end
  end

  // High-to-low is the active transition
  assign tick_pulse = prev_ff & ~tick_n;

endmodule

// File: rtl/pcr_flag_calc.sv
// Condition flag evaluation for logical, arithmetic and compare results
`timescale 1ns/1ps
module pcr_flag_calc (
  // Operation
  input wire pcr_pkg::pcr_flag_kind_t kind,
  input wire logic sub,
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  input wire logic [31:0] logic_result,
  // Flag values
  output logic lt,
  output logic eq,
  output logic gt,
  output logic carry,
  output logic ovf,
  output logic arith
);

  // ----------------------------------------------------------------
  // Adder
  // ----------------------------------------------------------------
  logic [31:0] b_eff; // Operand b, inverted for subtract
  logic [32:0] sum;   // Sum with carry out
  logic [31:0] res;   // Result that the flags describe

  // Subtract is a plus not-b plus one, carry out of the top bit kept
  always_comb begin
    b_eff = op_b ^ {32{sub}};
    sum = {1'b0, op_a} + {1'b0, b_eff} + {32'h00000000, sub};
    res = (kind == pcr_pkg::PCR_FK_ARITH) ? sum[31:0] : logic_result;
  end

  // Flag selection
  always_comb begin
    arith = (kind == pcr_pkg::PCR_FK_ARITH);
    carry = sum[32];
    ovf = (op_a[31] == b_eff[31]) && (sum[31] != op_a[31]);
    if (kind == pcr_pkg::PCR_FK_CMP) begin
      // Signed ordering of the comparands
      lt = $signed(op_a) < $signed(op_b);
      eq = (op_a == op_b);
      gt = $signed(op_a) > $signed(op_b);
    end else begin
      // Sign and zero of the result
      lt = res[31];
      eq = (res == 32'h00000000);
      gt = !res[31] && (res != 32'h00000000);
    end
  end

endmodule

// File: rtl/pcr_ctrl_regs.sv
// Processor control register bank with system interval timer
//
// Functional notes
// R01: Sixteen 32-bit registers addressed by number.
// R02: Reserved bits ignore writes; reads return zero.
// R03: Alarm copies reload into counter, reload unchanged.
// R04: Tick falling edge decrements counter; execution stalls.
// R05: Decrement from one reloads and starts alarm.
// R06: Enabled alarm sets request bit at priority.
// R07: Enable resets zero; counter runs regardless.
// R08: Status bit set on enabled alarm; sticky.
// R09: Overflow set by enabled alarm while status set.
// R10: Status field layout; priority in bits 29-31.
// R11: Request buffer bits 16-31, software writable.
// R12: Machine and program error status fields.
// R13: Instruction pointer bit 31 always zero.
// R14: Pointer advances by length or loads target.
// R15: Permanent zero flag always reads zero.
// R16: Less-than from sign or signed compare.
// R17: Equal from zero result or equal operands.
// R18: Greater-than from positive nonzero or compare.
// R19: Carry from arithmetic carry out; 29 reserved.
// R20: Overflow flag on signed arithmetic overflow.
// R21: Test bit from selected half-register bit.
// R22: Branch tests 16+n, jump tests 24+n.
// R23: Reload write leaves counter untouched.
// R24: Priority seven sets no request bit.
// R25: Zero counter wraps on tick, no alarm.
`timescale 1ns/1ps
module pcr_ctrl_regs #(
  parameter int unsigned IRB_LEVELS = pcr_pkg::DEF_IRB_LEVELS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register read
  input wire logic rd_en,
  input wire logic [3:0] rd_num,
  output logic [31:0] rd_data,
  output logic rd_valid,
  // Register write and bit clear
  input wire logic wr_en,
  input wire logic [3:0] wr_num,
  input wire logic [31:0] wr_data,
  input wire logic clr_en,
  input wire logic [3:0] clr_num,
  input wire logic [4:0] clr_bit,
  // Condition flag update
  input wire logic flag_en,
  input wire pcr_pkg::pcr_flag_kind_t flag_kind,
  input wire logic flag_sub,
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  input wire logic [31:0] logic_result,
  // Test bit move
  input wire logic tb_en,
  input wire logic [15:0] tb_half,
  input wire logic [3:0] tb_sel,
  // Instruction pointer
  input wire logic iptr_step,
  input wire logic [2:0] iptr_len,
  input wire logic iptr_load,
  input wire logic [31:0] iptr_target,
  // Condition test
  input wire logic cond_jump,
  input wire logic [3:0] cond_sel,
  output logic cond_taken,
  // Timer tick, active low
  input wire logic tick_n,
  // State toward the sequencer
  output logic exec_stall,
  output logic [31:0] next_instruction_pointer,
  output logic [15:0] soft_interrupt_request,
  output logic [15:0] interrupt_control_word
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Priority field is three bits and value seven must stay unused
  if (IRB_LEVELS < 1 || IRB_LEVELS > 7) begin : g_bad_levels
    $error("IRB_LEVELS must lie in 1..7");
  end

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Documented big-endian bit number to vector index
  function automatic logic [4:0] doc_idx(input logic [4:0] k);
    doc_idx = 5'h1F - k;
  endfunction

  // Bits that exist in a register; everything else is reserved
  function automatic logic [31:0] def_mask(input logic [3:0] num);
    case (num)
      pcr_pkg::REG_RELOAD: def_mask = pcr_pkg::MASK_FULL;
      pcr_pkg::REG_COUNT: def_mask = pcr_pkg::MASK_FULL;
      pcr_pkg::REG_TSTAT: def_mask = pcr_pkg::MASK_TSTAT;
      pcr_pkg::REG_MDEXT: def_mask = pcr_pkg::MASK_FULL;
      pcr_pkg::REG_ERR: def_mask = pcr_pkg::MASK_HALF;
      pcr_pkg::REG_IRB: def_mask = pcr_pkg::MASK_HALF;
      pcr_pkg::REG_IPTR: def_mask = pcr_pkg::MASK_IPTR;
      pcr_pkg::REG_ICW: def_mask = pcr_pkg::MASK_HALF;
      pcr_pkg::REG_FLAGS: def_mask = pcr_pkg::MASK_FLAGS;
      default: def_mask = pcr_pkg::MASK_NONE;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [31:0] regs_ff [pcr_pkg::NUM_REGS];   // Register storage
  logic [31:0] nxt_regs [pcr_pkg::NUM_REGS];  // Next storage
  logic [31:0] rd_data_ff, nxt_rd_data;       // Read data
  logic rd_valid_ff, nxt_rd_valid;            // Read answer strobe
  logic cond_ff, nxt_cond;                    // Condition test answer
  logic stall_ff, nxt_stall;                  // Counter update cycle

  // ----------------------------------------------------------------
  // Working signals
  // ----------------------------------------------------------------
  logic tick_pulse;          // Active tick edge
  logic sw_hit;              // Software write or clear this cycle
  logic [3:0] sw_num;        // Target of the software access
  logic [31:0] sw_val;       // Word the software access supplies
  logic [31:0] sw_mask;      // Implemented bits of the target
  logic [31:0] cur_count;    // Counter value before the update
  logic alarm;               // Decrement from one this cycle
  logic tmr_enable;          // Enable after software access
  logic old_status;          // Status after software access
  logic [2:0] tmr_prio;      // Priority field
  logic [4:0] cond_doc;      // Documented bit under test
  logic f_lt, f_eq, f_gt;    // Evaluated compare flags
  logic f_carry, f_ovf;      // Evaluated arithmetic flags
  logic f_arith;             // Carry and overflow apply

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  // Tick input is already synchronous, so only an edge is needed
  pcr_tick_edge u_tick (
    .clock(clock),
    .resetn(resetn),
    .tick_n(tick_n),
    .tick_pulse(tick_pulse)
  );

  // Flag evaluation shared by all flag-setting instruction classes
  pcr_flag_calc u_flags (
    .kind(flag_kind),
    .sub(flag_sub),
    .op_a(op_a),
    .op_b(op_b),
    .logic_result(logic_result),
    .lt(f_lt),
    .eq(f_eq),
    .gt(f_gt),
    .carry(f_carry),
    .ovf(f_ovf),
    .arith(f_arith)
  );

  // ----------------------------------------------------------------
  // Register update
  // ----------------------------------------------------------------
  // Software first, then hardware, so a hardware set beats a clear
  always_comb begin
    nxt_regs = regs_ff;
    // Write takes the word, clear drops one bit of the current word
    sw_hit = wr_en | clr_en;
    sw_num = wr_en ? wr_num : clr_num;
    sw_val = wr_en ? wr_data
                   : (regs_ff[clr_num] & ~(32'h00000001 << doc_idx(clr_bit)));
    sw_mask = def_mask(sw_num);
    if (sw_hit) begin
      // Reserved source bits discarded; reload write leaves counter R02 R23
      nxt_regs[sw_num] = (regs_ff[sw_num] & ~sw_mask) | (sw_val & sw_mask); // R01 R02 R11 R12
    end
    // Condition flags from the last operation
    if (flag_en && (flag_kind != pcr_pkg::PCR_FK_NONE)) begin
      nxt_regs[pcr_pkg::REG_FLAGS][doc_idx(pcr_pkg::LT_BIT)] = f_lt;  // R16
      nxt_regs[pcr_pkg::REG_FLAGS][doc_idx(pcr_pkg::EQ_BIT)] = f_eq;  // R17
      nxt_regs[pcr_pkg::REG_FLAGS][doc_idx(pcr_pkg::GT_BIT)] = f_gt;  // R18
      if (f_arith) begin
        nxt_regs[pcr_pkg::REG_FLAGS][doc_idx(pcr_pkg::CARRY_BIT)] = f_carry; // R19
        nxt_regs[pcr_pkg::REG_FLAGS][doc_idx(pcr_pkg::OVF_BIT)] = f_ovf;     // R20
      end
    end
    // Test bit takes a selected bit of a register half
    if (tb_en) begin
      nxt_regs[pcr_pkg::REG_FLAGS][doc_idx(pcr_pkg::TB_BIT)] = tb_half[4'hF - tb_sel]; // R21
    end
    // Permanent zero can never be loaded
    nxt_regs[pcr_pkg::REG_FLAGS][doc_idx(pcr_pkg::PZERO_BIT)] = 1'b0; // R15
    // Pointer: taken branch target wins over sequential advance
    if (iptr_load) begin
      nxt_regs[pcr_pkg::REG_IPTR] = iptr_target & pcr_pkg::MASK_IPTR; // R14 R13
    end else if (iptr_step) begin
      nxt_regs[pcr_pkg::REG_IPTR] = (regs_ff[pcr_pkg::REG_IPTR] + {29'h00000000, iptr_len})
                                    & pcr_pkg::MASK_IPTR; // R14 R13
    end
    // Timer update in the stalled cycle
    cur_count = regs_ff[pcr_pkg::REG_COUNT];
    tmr_enable = nxt_regs[pcr_pkg::REG_TSTAT][doc_idx(pcr_pkg::TS_ENABLE_BIT)];
    old_status = nxt_regs[pcr_pkg::REG_TSTAT][doc_idx(pcr_pkg::TS_STATUS_BIT)];
    tmr_prio = nxt_regs[pcr_pkg::REG_TSTAT][pcr_pkg::TS_PRIO_LSB +: 3]; // R10
    alarm = stall_ff && (cur_count == pcr_pkg::COUNT_ONE);
    if (stall_ff) begin
      if (alarm) begin
        // Reload from source; source itself is only read
        nxt_regs[pcr_pkg::REG_COUNT] = regs_ff[pcr_pkg::REG_RELOAD]; // R03 R05
      end else begin
        // Plain decrement, zero wraps to all ones with no alarm
        nxt_regs[pcr_pkg::REG_COUNT] = cur_count - 32'h00000001; // R04 R25
      end
    end
    // Alarm action gated only by enable; counter ran regardless
    if (alarm && tmr_enable) begin // R07
      if (old_status) begin
        nxt_regs[pcr_pkg::REG_TSTAT][doc_idx(pcr_pkg::TS_OVERFLOW_BIT)] = 1'b1; // R09
      end
      nxt_regs[pcr_pkg::REG_TSTAT][doc_idx(pcr_pkg::TS_STATUS_BIT)] = 1'b1; // R08
      // Priority seven, or any level beyond the buffer, sets nothing
      if (32'(tmr_prio) < IRB_LEVELS) begin // R24
        nxt_regs[pcr_pkg::REG_IRB][doc_idx(pcr_pkg::IRB_BASE_BIT + {2'h0, tmr_prio})] = 1'b1; // R06
      end
    end
  end

  // Storage; reset clears enable and every field
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < pcr_pkg::NUM_REGS; i++) begin
        regs_ff[i] <= pcr_pkg::RESET_WORD; // R07
      end
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // ----------------------------------------------------------------
  // Read, condition test and stall
  // ----------------------------------------------------------------
  // Reads answer one cycle later; reserved bits read zero
  always_comb begin
    nxt_rd_valid = rd_en;
    nxt_rd_data = rd_en ? (regs_ff[rd_num] & def_mask(rd_num)) : pcr_pkg::RESET_WORD; // R02
    // Branch selects from bit 16, jump from bit 24
    cond_doc = cond_jump ? (pcr_pkg::JUMP_BASE + {2'h0, cond_sel[2:0]})
                         : (pcr_pkg::BRANCH_BASE + {1'b0, cond_sel}); // R22
    nxt_cond = regs_ff[pcr_pkg::REG_FLAGS][doc_idx(cond_doc)] &
               pcr_pkg::MASK_FLAGS[doc_idx(cond_doc)];
    // Stall the cycle after the edge, which is the update cycle
    nxt_stall = tick_pulse; // R04
  end

  // Answer registers
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_data_ff <= pcr_pkg::RESET_WORD;
      rd_valid_ff <= 1'b0;
      cond_ff <= 1'b0;
      stall_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      cond_ff <= nxt_cond;
      stall_ff <= nxt_stall;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign cond_taken = cond_ff;
  assign exec_stall = stall_ff;
  assign next_instruction_pointer = regs_ff[pcr_pkg::REG_IPTR];
  assign soft_interrupt_request = regs_ff[pcr_pkg::REG_IRB][15:0];
  assign interrupt_control_word = regs_ff[pcr_pkg::REG_ICW][15:0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  // Update cycle from one, and an enabled alarm
  sequence s_alarm;
    stall_ff && regs_ff[pcr_pkg::REG_COUNT] == pcr_pkg::COUNT_ONE;
  endsequence
  sequence s_enabled_alarm;
    s_alarm ##0 tmr_enable;
  endsequence

  a_stall_follows_edge: assert property ( // R04
    tick_pulse |=> stall_ff ##1 !stall_ff || tick_pulse)
    else $error("stall not raised for exactly the update cycle");
  a_counter_dec: assert property ( // R04
    stall_ff && regs_ff[pcr_pkg::REG_COUNT] > pcr_pkg::COUNT_ONE
    |=> regs_ff[pcr_pkg::REG_COUNT] == $past(regs_ff[pcr_pkg::REG_COUNT]) - 32'h00000001)
    else $error("counter did not decrement by one");
  a_alarm_reload: assert property ( // R05
    s_alarm |=> regs_ff[pcr_pkg::REG_COUNT] == $past(regs_ff[pcr_pkg::REG_RELOAD]))
    else $error("counter not reloaded on alarm");
  a_reload_kept: assert property ( // R03
    s_alarm ##0 !(wr_en && wr_num == pcr_pkg::REG_RELOAD)
    |=> $stable(regs_ff[pcr_pkg::REG_RELOAD]))
    else $error("reload source changed by alarm");
  a_zero_wraps: assert property ( // R25
    stall_ff && regs_ff[pcr_pkg::REG_COUNT] == pcr_pkg::COUNT_ZERO
    |=> regs_ff[pcr_pkg::REG_COUNT] == pcr_pkg::MASK_FULL
    && !$rose(regs_ff[pcr_pkg::REG_TSTAT][doc_idx(pcr_pkg::TS_STATUS_BIT)]))
    else $error("zero counter did not wrap quietly");
  a_status_sets: assert property ( // R08
    s_enabled_alarm |=> regs_ff[pcr_pkg::REG_TSTAT][doc_idx(pcr_pkg::TS_STATUS_BIT)])
    else $error("status not set on enabled alarm");
  a_overflow_sets: assert property ( // R09
    s_enabled_alarm ##0 old_status
    |=> regs_ff[pcr_pkg::REG_TSTAT][doc_idx(pcr_pkg::TS_OVERFLOW_BIT)])
    else $error("overflow not set on repeated alarm");
  a_irb_level: assert property ( // R06
    s_enabled_alarm ##0 tmr_prio != 3'h7
    |=> regs_ff[pcr_pkg::REG_IRB][doc_idx(pcr_pkg::IRB_BASE_BIT + {2'h0, $past(tmr_prio)})])
    else $error("request bit at timer priority not set");
  a_disabled_quiet: assert property ( // R07
    s_alarm ##0 !tmr_enable ##0 !(sw_hit && sw_num == pcr_pkg::REG_IRB)
    |=> $stable(regs_ff[pcr_pkg::REG_IRB])
    && !$rose(regs_ff[pcr_pkg::REG_TSTAT][doc_idx(pcr_pkg::TS_STATUS_BIT)]))
    else $error("disabled alarm changed request buffer");
  a_prio_seven: assert property ( // R24
    s_enabled_alarm ##0 tmr_prio == 3'h7 ##0 !(sw_hit && sw_num == pcr_pkg::REG_IRB)
    |=> $stable(regs_ff[pcr_pkg::REG_IRB]))
    else $error("priority seven set a request bit");
  a_iptr_even: assert property ( // R13
    next_instruction_pointer[0] == 1'b0)
    else $error("instruction pointer odd");
  a_pzero_clear: assert property ( // R15
    !regs_ff[pcr_pkg::REG_FLAGS][doc_idx(pcr_pkg::PZERO_BIT)] and (cond_jump
    && cond_sel[2:0] == 3'h0 |=> !cond_taken))
    else $error("permanent zero read as one");

endmodule

// File: tb/pcr_seq_model.sv
// Sequencer-side model: drives the active-low tick and counts stalls
`timescale 1ns/1ps
module pcr_seq_model (
  // Clock
  input wire logic clock,
  // Tick request from the bench, stall seen from the design
  input wire logic fire,
  input wire logic exec_stall,
  // Toward the design and the bench
  output logic tick_n,
  output int stalls
);
  initial begin
    tick_n = 1'h1;
    stalls = 0;
  end
  // Tick held low three cycles, so that the edge detector sees one fall
  always @(posedge clock) begin
    if (fire) begin
      #1 tick_n = 1'h0;
      repeat (3) @(posedge clock);
      #1 tick_n = 1'h1;
    end
  end
  // Stall cycles; one per tick is expected
  always @(negedge clock) if (exec_stall) stalls++;
endmodule

// File: tb/tb_pcr_ctrl_regs.sv
// Self-checking bench for the control register bank and system timer
`timescale 1ns/1ps
module tb_pcr_ctrl_regs;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic clock = 1'h0, resetn = 1'h0, fire = 1'h0, rd_en = 1'h0, wr_en = 1'h0, clr_en = 1'h0;
  logic flag_en = 1'h0, flag_sub = 1'h0, tb_en = 1'h0, iptr_step = 1'h0, iptr_load = 1'h0;
  logic cond_jump = 1'h0, rd_valid, cond_taken, exec_stall, tick_n;
  logic [3:0] rd_num = 4'h0, wr_num = 4'h0, clr_num = 4'h0, tb_sel = 4'h0, cond_sel = 4'h0;
  logic [4:0] clr_bit = 5'h0;
  logic [2:0] iptr_len = 3'h0;
  logic [15:0] tb_half = 16'h0, soft_interrupt_request, interrupt_control_word;
  logic [31:0] wr_data = 32'h0, op_a = 32'h0, op_b = 32'h0, logic_result = 32'h0;
  logic [31:0] iptr_target = 32'h0, rd_data, next_instruction_pointer, r, r2;
  pcr_pkg::pcr_flag_kind_t flag_kind = pcr_pkg::PCR_FK_LOGIC;
  int n_tests = 0, n_mismatch = 0, stalls;
  logic [31:0] seed = 32'h00006103; // Start value 24835

  pcr_ctrl_regs u_pcr_ctrl_regs (.clock, .resetn, .rd_en, .rd_num, .rd_data, .rd_valid,
    .wr_en, .wr_num, .wr_data, .clr_en, .clr_num, .clr_bit, .flag_en, .flag_kind, .flag_sub,
    .op_a, .op_b, .logic_result, .tb_en, .tb_half, .tb_sel, .iptr_step, .iptr_len, .iptr_load,
    .iptr_target, .cond_jump, .cond_sel, .cond_taken, .tick_n, .exec_stall,
    .next_instruction_pointer, .soft_interrupt_request, .interrupt_control_word);
  pcr_seq_model u_pcr_seq_model (.clock, .fire, .exec_stall, .tick_n, .stalls);

  always #5 clock = ~clock;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Sign, zero and positive flags of a logical result at indices 6:4
  function automatic logic [31:0] exp_flags(input logic [31:0] v);
    return {25'h0, v[31], v == 32'h0, !v[31] && v != 32'h0, 4'h0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Kind 0 write, 1 bit clear, 2 logical flag update; one idle cycle before
  task automatic op(input int k, input logic [3:0] n, input logic [31:0] v);
    @(posedge clock); #1;
    wr_num = n; wr_data = v; clr_num = n; clr_bit = v[4:0]; logic_result = v;
    wr_en = (k == 0); clr_en = (k == 1); flag_en = (k == 2);
    @(posedge clock); #1;
    wr_en = 1'h0; clr_en = 1'h0; flag_en = 1'h0;
  endtask
  // Read answer stands one cycle after the request edge
  task automatic rd(input logic [3:0] n, input logic [31:0] e, input string nm);
    @(posedge clock); #1;
    rd_en = 1'h1; rd_num = n;
    @(posedge clock); #1;
    rd_en = 1'h0;
    chk("rd_valid", 32'h1, {31'h0, rd_valid});
    chk(nm, e, rd_data);
  endtask
  task automatic tick();
    @(posedge clock); #1 fire = 1'h1;
    @(posedge clock); #1 fire = 1'h0;
    repeat (6) @(posedge clock);
    #1;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog, far beyond the fewer than two hundred cycles the tests need
  // ----------------------------------------------------------------
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clock);
    #1 resetn = 1'h1;
    rd(pcr_pkg::REG_TSTAT, 32'h0, "timer status at reset");
    op(0, 4'h0, xs());
    rd(4'h0, 32'h0, "reserved register");
    $display("reset test done");
    r = xs();
    op(0, pcr_pkg::REG_RELOAD, r);
    op(0, pcr_pkg::REG_COUNT, 32'h2);
    op(0, pcr_pkg::REG_TSTAT, 32'hFFFFFFCD); // Enable, level 5, reserved bits set
    rd(pcr_pkg::REG_TSTAT, 32'h45, "status layout");
    tick();
    rd(pcr_pkg::REG_COUNT, 32'h1, "count after tick");
    tick();
    rd(pcr_pkg::REG_COUNT, r, "count reloaded");
    rd(pcr_pkg::REG_RELOAD, r, "reload kept");
    rd(pcr_pkg::REG_TSTAT, 32'h65, "status after alarm");
    chk("request level 5", 32'h0400, {16'h0, soft_interrupt_request});
    r2 = xs();
    op(0, pcr_pkg::REG_RELOAD, r2);
    rd(pcr_pkg::REG_COUNT, r, "count after reload write");
    op(0, pcr_pkg::REG_COUNT, 32'h1);
    tick();
    rd(pcr_pkg::REG_TSTAT, 32'h75, "overflow on second alarm");
    rd(pcr_pkg::REG_COUNT, r2, "count from new reload");
    op(1, pcr_pkg::REG_TSTAT, 32'h1A);
    rd(pcr_pkg::REG_TSTAT, 32'h55, "status cleared");
    $display("alarm test done");
    op(0, pcr_pkg::REG_IRB, 32'h0);
    op(0, pcr_pkg::REG_TSTAT, 32'h05);
    op(0, pcr_pkg::REG_COUNT, 32'h1);
    tick();
    rd(pcr_pkg::REG_TSTAT, 32'h05, "disabled alarm status");
    rd(pcr_pkg::REG_COUNT, r2, "disabled alarm reload");
    op(0, pcr_pkg::REG_TSTAT, 32'h47);
    op(0, pcr_pkg::REG_COUNT, 32'h1);
    tick();
    rd(pcr_pkg::REG_TSTAT, 32'h67, "level 7 alarm status");
    chk("no request at level 7", 32'h0, {16'h0, soft_interrupt_request});
    op(0, pcr_pkg::REG_COUNT, 32'h0);
    tick();
    rd(pcr_pkg::REG_COUNT, 32'hFFFFFFFF, "wrapped count");
    rd(pcr_pkg::REG_TSTAT, 32'h67, "no alarm on wrap");
    chk("stall cycles", 32'h6, stalls);
    $display("timer test done");
    r = xs();
    op(0, pcr_pkg::REG_IRB, r);
    chk("request buffer", {16'h0, r[15:0]}, {16'h0, soft_interrupt_request});
    op(0, pcr_pkg::REG_ICW, r);
    chk("control word", {16'h0, r[15:0]}, {16'h0, interrupt_control_word});
    op(0, pcr_pkg::REG_IPTR, r | 32'h1);
    chk("pointer low bit", r & 32'hFFFFFFFE, next_instruction_pointer);
    op(0, pcr_pkg::REG_FLAGS, 32'hFFFFFFFF);
    rd(pcr_pkg::REG_FLAGS, 32'h7B, "flags permanent zero");
    cond_jump = 1'h1;
    cond_sel = 4'h9;
    for (int i = 0; i < 8; i++) begin
      r = (i == 0) ? 32'h0 : xs();
      op(2, 4'h0, r);
      rd(pcr_pkg::REG_FLAGS, exp_flags(r) | 32'h0B, "logic flags");
      chk("jump on less", {31'h0, r[31]}, {31'h0, cond_taken});
    end
    $display("flag test done");
    close_out();
  end
endmodule
